// File: design/adcc_core.v
`timescale 1ns/1ps
`include "adcc_map.vh"
module adcc_core #(
    parameter CLK_DIV = 8'h08
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    // avalon-mm slave
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // system integration
    input  wire        stop_mode,
    input  wire        debug_break,
    input  wire        break_clear_enable,
    // analog front end
    input  wire        cmp_in,
    output reg  [4:0]  analog_channel,
    output reg         analog_power,
    output reg         pad_isolate,
    output reg  [9:0]  dac_code,
    // interrupt request
    output reg         conversion_irq
);
    // ************************************************************
    // registers
    // ************************************************************
    reg        conversion_done_flag_reg;
    reg        conversion_irq_enable_reg;
    reg        continuous_conversion_bit_reg;
    reg  [4:0] channel_select_field_reg;
    reg  [7:0] converter_clock_register_reg;
    reg  [9:0] result_reg;
    reg        hi_lock_reg;
    reg        ack_reg;
    reg        halted_reg;
    reg  [7:0] div_reg;
    reg        tick_reg;
    reg        stop_d_reg;

    wire       busy;
    wire       done;
    wire [9:0] code;
    wire       mode_10bit;
    wire       ch_off;
    wire       start;
    wire       abort;
    wire       sel_csc;
    wire       sel_hi;
    wire       sel_lo;
    wire       sel_clk;
    wire       wr_csc;
    wire       wr_clk;
    wire       rd_hi;
    wire       rd_lo;
    wire       may_clear;
    wire       stop_rise;

    // one-cycle answer: wait while the access is not yet acknowledged
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

    // decode on the accepting cycle only so each access acts once
    assign sel_csc = (avs_address[3:2] == `ADCC_IDX_CSC);
    assign sel_hi  = (avs_address[3:2] == `ADCC_IDX_RES_HI);
    assign sel_lo  = (avs_address[3:2] == `ADCC_IDX_RES_LO);
    assign sel_clk = (avs_address[3:2] == `ADCC_IDX_CLK);
    assign wr_csc  = ack_reg & avs_write & sel_csc & avs_byteenable[0];
    assign wr_clk  = ack_reg & avs_write & sel_clk & avs_byteenable[0];
    assign rd_hi   = ack_reg & avs_read & sel_hi;
    assign rd_lo   = ack_reg & avs_read & sel_lo;

    // status clears only outside a break, or in a break when enabled
    assign may_clear = ~debug_break | break_clear_enable;

    assign mode_10bit = (converter_clock_register_reg[`ADCC_CLK_MODE_MSB:`ADCC_CLK_MODE_LSB]
                         == `ADCC_MODE_10BIT);
    assign ch_off     = (avs_writedata[`ADCC_CH_MSB:0] == `ADCC_CH_OFF);
    assign stop_rise  = stop_mode & ~stop_d_reg;

    // any control write aborts; it restarts unless channel is off
    assign start = wr_csc & ~ch_off;
    // continuous halts on clock write, stop entry or off-write
    assign abort = wr_csc | wr_clk | (stop_rise & ~halted_reg);

    // ************************************************************
    // bus handshake
    // ************************************************************
    always @(posedge clk_sys)
    begin
        if (!rst_n)
            ack_reg <= 1'b0;
        else
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end

    // read mux; unmapped bits read zero
    always @(posedge clk_sys)
    begin
        if (!rst_n)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read & ~ack_reg)
        begin
            case (avs_address[3:2])
                `ADCC_IDX_CSC:    avs_readdata <= {24'h000000, conversion_done_flag_reg,
                                                   conversion_irq_enable_reg, continuous_conversion_bit_reg,
                                                   channel_select_field_reg};
                `ADCC_IDX_RES_HI: avs_readdata <= mode_10bit ? {30'h0, result_reg[9:8]}
                                                             : 32'h0000_0000;
                `ADCC_IDX_RES_LO: avs_readdata <= mode_10bit ? {24'h000000, result_reg[7:0]}
                                                             : {24'h000000, result_reg[9:2]};
                `ADCC_IDX_CLK:    avs_readdata <= {24'h000000, converter_clock_register_reg};
                default:          avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // control and status
    // ************************************************************
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            conversion_irq_enable_reg     <= 1'b0;
            continuous_conversion_bit_reg <= 1'b0;
            channel_select_field_reg      <= `ADCC_CH_OFF;
            converter_clock_register_reg  <= `ADCC_CLK_RESET;
            halted_reg                    <= 1'b0;
            stop_d_reg                    <= 1'b0;
        end
        else
        begin
            stop_d_reg <= stop_mode;
            if (wr_csc)
            begin
                conversion_irq_enable_reg     <= avs_writedata[`ADCC_CSC_IRQEN];
                continuous_conversion_bit_reg <= avs_writedata[`ADCC_CSC_CONT];
                channel_select_field_reg      <= avs_writedata[`ADCC_CH_MSB:0];
                halted_reg                    <= 1'b0;
            end
            else if (stop_rise | wr_clk)
                halted_reg <= 1'b1;
            if (wr_clk)
                converter_clock_register_reg <= avs_writedata[7:0];
        end
    end

    // done flag: set beats clear; clears held in protected break
    always @(posedge clk_sys)
    begin
        if (!rst_n)
            conversion_done_flag_reg <= 1'b0;
        else if (done & ~hi_lock_reg)
            conversion_done_flag_reg <= 1'b1;
        else if ((wr_csc | rd_lo) & may_clear)
            conversion_done_flag_reg <= 1'b0;
    end

    // irq: raised per conversion when enabled, cleared on result read
    always @(posedge clk_sys)
    begin
        if (!rst_n)
            conversion_irq <= 1'b0;
        else if (done & ~hi_lock_reg & conversion_irq_enable_reg)
            conversion_irq <= 1'b1;
        else if ((wr_csc | rd_lo | rd_hi) & may_clear)
            conversion_irq <= 1'b0;
    end

    // high-byte read lock: second step (low read) frees it
    always @(posedge clk_sys)
    begin
        if (!rst_n)
            hi_lock_reg <= 1'b0;
        else if (rd_lo & may_clear)
            hi_lock_reg <= 1'b0;
        else if (rd_hi & mode_10bit & may_clear)
            hi_lock_reg <= 1'b1;
    end

    // result latch; a locked result drops the new conversion
    always @(posedge clk_sys)
    begin
        if (!rst_n)
            result_reg <= 10'h000;
        else if (done & ~hi_lock_reg)
            result_reg <= code;
    end

    // ************************************************************
    // conversion clock and restart
    // ************************************************************
    // conversion clock is an enable pulse; bus clock must not lag it
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            div_reg  <= 8'h00;
            tick_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= (div_reg == 8'h00);
            div_reg  <= (div_reg == 8'h00) ? (CLK_DIV - 8'h01) : (div_reg - 8'h01);
        end
    end

    // next sample in continuous mode starts right after done
    wire cont_restart = done & continuous_conversion_bit_reg & ~halted_reg &
                        (channel_select_field_reg != `ADCC_CH_OFF) & ~wr_csc & ~wr_clk;

    adcc_sar_seq #(
        .BITS        (10)
    ) u_seq (
        .clk_sys     (clk_sys),
        .rst_n       (rst_n),
        .tick        (tick_reg),
        .start       (start | cont_restart),
        .abort       (abort),
        .long_sample (converter_clock_register_reg[`ADCC_CLK_LSMP]),
        .cmp_in      (cmp_in),
        .busy_reg    (busy),
        .done_reg    (done),
        .code_reg    (code)
    );

    // ************************************************************
    // analog front end; no hardware trigger input exists
    // ************************************************************
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            analog_channel <= `ADCC_CH_OFF;
            analog_power   <= 1'b0;
            pad_isolate    <= 1'b1;
            dac_code       <= 10'h000;
        end
        else
        begin
            analog_channel <= channel_select_field_reg;
            analog_power   <= busy;
            pad_isolate    <= (channel_select_field_reg == `ADCC_CH_OFF);
            dac_code       <= code;
        end
    end
endmodule // adcc_core

// File: design/adcc_map.vh
`ifndef ADCC_MAP_VH
`define ADCC_MAP_VH
// register word offsets (byte address = 4 * index)
`define ADCC_IDX_CSC        2'h0
`define ADCC_IDX_RES_HI     2'h1
`define ADCC_IDX_RES_LO     2'h2
`define ADCC_IDX_CLK        2'h3
// status/control fields
`define ADCC_CSC_DONE       7
`define ADCC_CSC_IRQEN      6
`define ADCC_CSC_CONT       5
`define ADCC_CH_MSB         4
`define ADCC_CH_OFF         5'h1f
`define ADCC_CSC_RESET      8'h1f
// clock register fields
`define ADCC_CLK_LSMP       4
`define ADCC_CLK_MODE_MSB   3
`define ADCC_CLK_MODE_LSB   2
`define ADCC_CLK_RESET      8'h00
`define ADCC_MODE_10BIT     2'h1
// channel codes
`define ADCC_CH_EXT_MAX     5'h05
`define ADCC_CH_BANDGAP     5'h1a
`define ADCC_CH_VREFH       5'h1d
`define ADCC_CH_VREFL       5'h1e
// sample lengths in conversion clocks
`define ADCC_SAMPLE_SHORT   5'h04
`define ADCC_SAMPLE_LONG    5'h18
`endif

// File: design/adcc_sar_seq.v
`timescale 1ns/1ps
// ************************************************************
// successive-approximation sequencer
// ************************************************************
module adcc_sar_seq #(
    parameter BITS = 10
) (
    // clock and reset
    input  wire            clk_sys,
    input  wire            rst_n,
    // control
    input  wire            tick,
    input  wire            start,
    input  wire            abort,
    input  wire            long_sample,
    input  wire            cmp_in,
    // results
    output reg             busy_reg,
    output reg             done_reg,
    output reg  [BITS-1:0] code_reg
);
    localparam S_IDLE   = 2'h0;
    localparam S_SAMPLE = 2'h1;
    localparam S_CONV   = 2'h2;

    reg [1:0]      state_reg;
    reg [4:0]      cnt_reg;
    reg [BITS-1:0] trial_reg;

    // sequencer; start wins over abort since a write restarts
    always @(posedge clk_sys)
    begin
        done_reg <= 1'b0;
        if (!rst_n)
        begin
            state_reg <= S_IDLE;
            busy_reg  <= 1'b0;
            cnt_reg   <= 5'h00;
            trial_reg <= {BITS{1'b0}};
            code_reg  <= {BITS{1'b0}};
        end
        else if (start)
        begin
            state_reg <= S_SAMPLE;
            busy_reg  <= 1'b1;
            cnt_reg   <= long_sample ? `ADCC_SAMPLE_LONG : `ADCC_SAMPLE_SHORT;
            trial_reg <= {1'b1, {(BITS-1){1'b0}}};
            // code holds the live trial, so no result of an earlier run leaks in
            code_reg  <= {1'b1, {(BITS-1){1'b0}}};
        end
        else if (abort)
        begin
            state_reg <= S_IDLE;
            busy_reg  <= 1'b0;
        end
        else if (tick)
        begin
            case (state_reg)
                S_SAMPLE:
                begin
                    if (cnt_reg == 5'h00)
                        state_reg <= S_CONV;
                    else
                        cnt_reg <= cnt_reg - 5'h01;
                end
                S_CONV:
                begin
                    // drop the trial bit when the input sits below it, then try the next
                    if (trial_reg == {{(BITS-1){1'b0}}, 1'b1})
                    begin
                        code_reg  <= cmp_in ? code_reg : (code_reg & ~trial_reg);
                        state_reg <= S_IDLE;
                        busy_reg  <= 1'b0;
                        done_reg  <= 1'b1;
                    end
                    else
                    begin
                        code_reg  <= (cmp_in ? code_reg : (code_reg & ~trial_reg)) | (trial_reg >> 1);
                        trial_reg <= trial_reg >> 1;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule // adcc_sar_seq

// File: tb/adcc_core_monitor.sv
`timescale 1ns/1ps
// ****************************************
// port checker
// ****************************************
module adcc_core_monitor (
    // clock, reset, bus
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // system and analog
    input wire logic        stop_mode,
    input wire logic        debug_break,
    input wire logic        break_clear_enable,
    input wire logic        analog_power,
    input wire logic        pad_isolate,
    input wire logic        conversion_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // accepted control write and low read; break without enable masks clears
    wire cw = avs_write & ~avs_waitrequest & (avs_address[3:2] == 2'h0) & avs_byteenable[0];
    wire lr = avs_read & ~avs_waitrequest & (avs_address[3:2] == 2'h2);
    wire ok = ~analog_power & ~debug_break;
    chk_bus_answer: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held past one cycle");
    chk_ctrl_start: assert property (cw && avs_writedata[4:0] != 5'h1f |-> ##[1:4] analog_power)
        else $error("control write started no conversion");
    chk_off_write: assert property (cw && avs_writedata[4:0] == 5'h1f |-> ##3 (!analog_power)[*8])
        else $error("converter ran after off write");
    chk_isolate_off: assert property (pad_isolate |-> !analog_power)
        else $error("isolated channel while powered");
    chk_irq_at_end: assert property ($rose(conversion_irq) |-> $past(analog_power) || $past(analog_power, 2))
        else $error("irq without a conversion ending");
    chk_write_clear: assert property (cw && ok |=> !conversion_irq)
        else $error("irq kept after control write");
    chk_read_clear: assert property (lr && ok |=> !conversion_irq)
        else $error("irq kept after result read");
    chk_stop_halt: assert property ($rose(stop_mode) |-> ##[1:4] !analog_power)
        else $error("conversion kept running in stop");
    chk_break_hold: assert property (debug_break && !break_clear_enable && conversion_irq |=> conversion_irq)
        else $error("irq cleared during protected break");
    chk_data_stand: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without a read");
endmodule // adcc_core_monitor

bind adcc_core adcc_core_monitor u_mon (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .stop_mode(stop_mode),
    .debug_break(debug_break), .break_clear_enable(break_clear_enable), .analog_power(analog_power),
    .pad_isolate(pad_isolate), .conversion_irq(conversion_irq));

// File: tb/adcc_front_model.sv
`timescale 1ns/1ps
// ****************************************
// analog input and comparator model
// ****************************************
module adcc_front_model (
    // from the converter
    input  wire logic [4:0] analog_channel,
    input  wire logic [9:0] dac_code,
    input  wire logic       analog_power,
    // comparator answer
    output wire logic       cmp_in
);
    // level per channel is {channel, 5'h0b}; the compare is dac_code <= level, so the search settles exactly on it
    wire [9:0] level = {analog_channel, 5'h0b};
    // unpowered comparator toggles with the trial code rather than holding a stale answer
    assign cmp_in = analog_power ? (dac_code <= level) : dac_code[0];
endmodule // adcc_front_model

// File: tb/tb_adcc_core.sv
`timescale 1ns/1ps
module tb_adcc_core;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic        stop_mode = 1'b0;
    logic        debug_break = 1'b0;
    logic        break_clear_enable = 1'b0;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest, cmp_in, analog_power, pad_isolate, conversion_irq;
    wire  [4:0]  analog_channel;
    wire  [9:0]  dac_code;
    int          fails = 0;
    int          comparisons = 0;
    logic [7:0]  rd;
    logic [4:0]  chs [5] = '{5'h00, 5'h05, 5'h1a, 5'h1d, 5'h1e};
    // short divider keeps runs brief; bus clock stays above conversion clock
    adcc_core #(.CLK_DIV(8'h02)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .stop_mode(stop_mode),
        .debug_break(debug_break), .break_clear_enable(break_clear_enable), .cmp_in(cmp_in),
        .analog_channel(analog_channel), .analog_power(analog_power), .pad_isolate(pad_isolate),
        .dac_code(dac_code), .conversion_irq(conversion_irq));
    adcc_front_model u_front (.analog_channel(analog_channel), .dac_code(dac_code),
        .analog_power(analog_power), .cmp_in(cmp_in));
    // ****************************************
    // clock, reset, watchdog
    // ****************************************
    initial forever #2 clk_sys = ~clk_sys;
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
    end
    initial
    begin
        repeat (30000) @(posedge clk_sys);
        fails++;
        results();
    end
    // ****************************************
    // bus and compare tasks
    // ****************************************
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // request held until waitrequest seen low; data taken at that edge
    task bus(input logic w, input logic [1:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_read <= ~w;
        avs_write <= w;
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, wd};
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 100);
        if (avs_waitrequest !== 1'b0) fails++;
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task rdchk(input logic [1:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rd, exp);
    endtask
    task wait_irq();
        int n;
        n = 0;
        while (conversion_irq !== 1'b1 && n < 500)
        begin
            n++;
            @(negedge clk_sys);
        end
        chk(conversion_irq, 1'b1);
    endtask
    task poll_done();
        int n;
        n = 0;
        rd = 8'h00;
        while (rd[7] !== 1'b1 && n < 50)
        begin
            bus(1'b0, 2'h0, 8'h00);
            n++;
        end
        chk(rd[7], 1'b1);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_reset();
        chk({pad_isolate, analog_power}, 2'b10);
        rdchk(2'h0, 8'h1f);
        bus(1'b1, 2'h0, 8'h9f);
        rdchk(2'h0, 8'h1f);
        bus(1'b1, 2'h3, 8'h04);
    endtask
    task t_single();
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b1, 2'h0, 8'h40 | chs[i]);
            wait_irq();
            rdchk(2'h0, 8'hc0 | chs[i]);
            rdchk(2'h1, {6'h00, chs[i][4:3]});
            @(negedge clk_sys);
            chk(conversion_irq, 1'b0);
            rdchk(2'h2, {chs[i][2:0], 5'h0b});
            rdchk(2'h0, 8'h40 | chs[i]);
            repeat (80) @(posedge clk_sys);
            rdchk(2'h0, 8'h40 | chs[i]);
            chk(analog_power, 1'b0);
        end
    endtask
    task t_cont();
        bus(1'b1, 2'h0, 8'h22);
        poll_done();
        rdchk(2'h2, 8'h4b);
        poll_done();
        stop_mode <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rdchk(2'h2, 8'h4b);
        repeat (80) @(posedge clk_sys);
        rdchk(2'h0, 8'h22);
        stop_mode <= 1'b0;
        repeat (80) @(posedge clk_sys);
        rdchk(2'h0, 8'h22);
        bus(1'b1, 2'h0, 8'h23);
        poll_done();
        bus(1'b1, 2'h0, 8'h1f);
        repeat (80) @(posedge clk_sys);
        rdchk(2'h0, 8'h1f);
        chk({pad_isolate, analog_power}, 2'b10);
    endtask
    task t_break();
        bus(1'b1, 2'h0, 8'h41);
        wait_irq();
        @(posedge clk_sys);
        debug_break <= 1'b1;
        rdchk(2'h2, 8'h2b);
        rdchk(2'h0, 8'hc1);
        chk(conversion_irq, 1'b1);
        break_clear_enable <= 1'b1;
        rdchk(2'h2, 8'h2b);
        @(negedge clk_sys);
        chk(conversion_irq, 1'b0);
        @(posedge clk_sys);
        debug_break <= 1'b0;
        break_clear_enable <= 1'b0;
        rdchk(2'h0, 8'h41);
    endtask
    task results();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        @(posedge rst_n);
        t_reset();
        t_single();
        t_cont();
        t_break();
        results();
    end
endmodule // tb_adcc_core
